// *** hw/ffi_map.svh ***
// Register offsets, field positions, codes and reset values for fault irq
`ifndef FFI_MAP_SVH
`define FFI_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FFI_OFS_LED_EN 8'h0C
`define FFI_OFS_SUPPLY 8'h0E
`define FFI_OFS_CONV 8'h10

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FFI_RST_LED_EN 16'h00AA
`define FFI_RST_SUPPLY 16'h0000
`define FFI_RST_CONV 16'h0000

// ----------------------------------------------------------------------
// Enable field positions (low bit of each two-bit field)
// ----------------------------------------------------------------------
`define FFI_LSB_GLOBAL 6
`define FFI_LSB_TIMEOUT 4
`define FFI_LSB_STRING 2
`define FFI_LSB_LEDF 0

// ----------------------------------------------------------------------
// Enable field codes
// ----------------------------------------------------------------------
`define FFI_WR_DISABLE 2'h1
`define FFI_WR_ENABLE 2'h3
`define FFI_RD_DISABLED 2'h0
`define FFI_RD_ENABLED 2'h2

// ----------------------------------------------------------------------
// Supply fault pairs: flag at 2*k+1, ack at 2*k
// ----------------------------------------------------------------------
`define FFI_PAIR_CHECKSUM 7
`define FFI_PAIR_SYNC_LOSS 6
`define FFI_PAIR_PUMP 5
`define FFI_PAIR_PUMP_CAP 4
`define FFI_PAIR_IN_OVERCURRENT 3
`define FFI_PAIR_REG_UNDERVOLT 2
`define FFI_PAIR_IN_OVERVOLT 1
`define FFI_PAIR_IN_UNDERVOLT 0

`endif

// *** hw/ffi_pkg.sv ***
// Types shared by the fault interrupt enable and status block
`default_nettype none
package ffi_pkg;
   typedef logic [7:0] ffi_addr_t;
   typedef logic [15:0] ffi_word_t;
   typedef enum logic [1:0] {
      FFI_SEL_NONE,
      FFI_SEL_LED_EN,
      FFI_SEL_SUPPLY,
      FFI_SEL_CONV
   } ffi_reg_sel_t;
endpackage
`default_nettype wire

// *** hw/ffi_flag_pair.sv ***
// One sticky fault flag with its paired clear request
`default_nettype none
module ffi_flag_pair (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic fault,
   input wire logic clr_req,
   output logic flag
);
   // A fault present in the clear cycle keeps the flag set
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         flag <= 1'b0;
      end else if (fault) begin
         flag <= 1'b1;
      end else if (clr_req) begin
         flag <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** hw/ffi_top.sv ***
// Fault interrupt enables, supply and converter fault flags, irq output
//
// Strobed register access was chosen for this implementation.
`include "ffi_map.svh"
`default_nettype none
module ffi_top
   import ffi_pkg::*;
#(
   parameter int PAIRS = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic [PAIRS-1:0] supply_fault_in,
   input wire logic [PAIRS-1:0] conv_fault_in,
   input wire logic [PAIRS-1:0] supply_irq_gate,
   input wire logic [PAIRS-1:0] conv_irq_gate,
   input wire logic bus_timeout_flag,
   input wire logic bad_string_flag,
   input wire logic led_fault_flag,
   output logic fault_irq,
   output logic global_irq_on,
   output logic [PAIRS-1:0] supply_flags,
   output logic [PAIRS-1:0] conv_flags
);

   // -------------------------------------------------------------------
   // Field indices of the enable register
   // -------------------------------------------------------------------
   localparam int FIELDS = 4;
   localparam int F_LEDF = 0;
   localparam int F_STRING = 1;
   localparam int F_TIMEOUT = 2;
   localparam int F_GLOBAL = 3;

   // Low bit of each field, indexed by field number
   function automatic int field_lsb(input int f);
      int lsb;
      lsb = `FFI_LSB_LEDF;
      if (f == F_STRING) begin
         lsb = `FFI_LSB_STRING;
      end
      if (f == F_TIMEOUT) begin
         lsb = `FFI_LSB_TIMEOUT;
      end
      if (f == F_GLOBAL) begin
         lsb = `FFI_LSB_GLOBAL;
      end
      return lsb;
   endfunction

   // -------------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------------
   ffi_reg_sel_t reg_sel;
   wire logic hit_led_en;
   wire logic hit_supply;
   wire logic hit_conv;
   wire logic wr_led_en;
   wire logic wr_supply;
   wire logic wr_conv;

   assign hit_led_en = (reg_addr == `FFI_OFS_LED_EN);
   assign hit_supply = (reg_addr == `FFI_OFS_SUPPLY);
   assign hit_conv = (reg_addr == `FFI_OFS_CONV);
   assign reg_sel = hit_led_en ? FFI_SEL_LED_EN :
                    hit_supply ? FFI_SEL_SUPPLY :
                    hit_conv ? FFI_SEL_CONV : FFI_SEL_NONE;
   assign wr_led_en = reg_wr && (reg_sel == FFI_SEL_LED_EN);
   assign wr_supply = reg_wr && (reg_sel == FFI_SEL_SUPPLY);
   assign wr_conv = reg_wr && (reg_sel == FFI_SEL_CONV);

   // -------------------------------------------------------------------
   // Interrupt enable fields
   // -------------------------------------------------------------------
   // Only one state bit per field is kept; the two-bit read code is
   // rebuilt from it, so codes 0h and 2h written by software are no-ops
   logic [FIELDS-1:0] field_on;
   wire logic [FIELDS-1:0] field_wr_on;
   wire logic [FIELDS-1:0] field_wr_off;
   wire logic [15:0] led_en_rd;

   genvar gf;
   generate
      for (gf = 0; gf < FIELDS; gf++) begin : g_field
         localparam int LSB = field_lsb(gf);
         localparam logic RST_ON = 1'(`FFI_RST_LED_EN >> (LSB + 1));
         wire logic [1:0] code;

         assign code = reg_wdata[LSB+1:LSB];
         assign field_wr_on[gf] = wr_led_en &&
                                  (code == `FFI_WR_ENABLE);
         assign field_wr_off[gf] = wr_led_en &&
                                   (code == `FFI_WR_DISABLE);

         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               field_on[gf] <= RST_ON;
            end else if (field_wr_on[gf]) begin
               field_on[gf] <= 1'b1;
            end else if (field_wr_off[gf]) begin
               field_on[gf] <= 1'b0;
            end
         end

         assign led_en_rd[LSB+1:LSB] = field_on[gf] ?
            `FFI_RD_ENABLED : `FFI_RD_DISABLED;
      end
   endgenerate

   // Upper byte is reserved and always reads zero
   assign led_en_rd[15:8] = 8'h00;

   // -------------------------------------------------------------------
   // Fault input synchronisers
   // -------------------------------------------------------------------
   // Fault detectors are analog comparators, so each line is resampled
   logic [PAIRS-1:0] supply_meta;
   logic [PAIRS-1:0] supply_sync;
   logic [PAIRS-1:0] conv_meta;
   logic [PAIRS-1:0] conv_sync;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         supply_meta <= '0;
         supply_sync <= '0;
         conv_meta <= '0;
         conv_sync <= '0;
      end else begin
         supply_meta <= supply_fault_in;
         supply_sync <= supply_meta;
         conv_meta <= conv_fault_in;
         conv_sync <= conv_meta;
      end
   end

   // -------------------------------------------------------------------
   // Sticky flags with paired clear bits
   // -------------------------------------------------------------------
   wire logic [PAIRS-1:0] supply_clr;
   wire logic [PAIRS-1:0] conv_clr;
   wire logic [PAIRS-1:0] supply_flag_q;
   wire logic [PAIRS-1:0] conv_flag_q;
   wire logic [15:0] supply_rd;
   wire logic [15:0] conv_rd;

   genvar gp;
   generate
      for (gp = 0; gp < PAIRS; gp++) begin : g_pair
         // Both bits of the pair must be one in the same write
         assign conv_clr[gp] = wr_conv && reg_wdata[2*gp+1] &&
                               reg_wdata[2*gp];

         ffi_flag_pair u_supply (
            .mclk(mclk),
            .rst_n(rst_n),
            .fault(supply_sync[gp]),
            .clr_req(supply_clr[gp]),
            .flag(supply_flag_q[gp])
         );

         ffi_flag_pair u_conv (
            .mclk(mclk),
            .rst_n(rst_n),
            .fault(conv_sync[gp]),
            .clr_req(conv_clr[gp]),
            .flag(conv_flag_q[gp])
         );

         // Clear bits are write-only strobes and read back zero
         assign supply_rd[2*gp+1] = supply_flag_q[gp];
         assign supply_rd[2*gp] = 1'b0;
         assign conv_rd[2*gp+1] = conv_flag_q[gp];
         assign conv_rd[2*gp] = 1'b0;
      end
   endgenerate

   // -------------------------------------------------------------------
   // Named supply fault flags
   // -------------------------------------------------------------------
   wire logic checksum_fault_flag;
   wire logic sync_loss_flag;
   wire logic pump_fault_flag;
   wire logic pump_capacitor_flag;
   wire logic input_overcurrent_flag;
   wire logic regulator_undervolt_flag;
   wire logic input_overvolt_flag;
   wire logic input_undervolt_flag;

   assign checksum_fault_flag =
      supply_flag_q[`FFI_PAIR_CHECKSUM];
   assign sync_loss_flag =
      supply_flag_q[`FFI_PAIR_SYNC_LOSS];
   assign pump_fault_flag =
      supply_flag_q[`FFI_PAIR_PUMP];
   assign pump_capacitor_flag =
      supply_flag_q[`FFI_PAIR_PUMP_CAP];
   assign input_overcurrent_flag =
      supply_flag_q[`FFI_PAIR_IN_OVERCURRENT];
   assign regulator_undervolt_flag =
      supply_flag_q[`FFI_PAIR_REG_UNDERVOLT];
   assign input_overvolt_flag =
      supply_flag_q[`FFI_PAIR_IN_OVERVOLT];
   assign input_undervolt_flag =
      supply_flag_q[`FFI_PAIR_IN_UNDERVOLT];

   // -------------------------------------------------------------------
   // Named supply clear requests
   // -------------------------------------------------------------------
   // A lone flag bit or a lone clear bit must not clear the pair
   wire logic checksum_fault_ack;
   wire logic sync_loss_ack;
   wire logic pump_fault_ack;
   wire logic pump_capacitor_ack;
   wire logic input_overcurrent_ack;
   wire logic regulator_undervolt_ack;
   wire logic input_overvolt_ack;
   wire logic input_undervolt_ack;

   assign checksum_fault_ack = wr_supply &&
      (&reg_wdata[2*`FFI_PAIR_CHECKSUM+1 -: 2]);
   assign sync_loss_ack = wr_supply &&
      (&reg_wdata[2*`FFI_PAIR_SYNC_LOSS+1 -: 2]);
   assign pump_fault_ack = wr_supply &&
      (&reg_wdata[2*`FFI_PAIR_PUMP+1 -: 2]);
   assign pump_capacitor_ack = wr_supply &&
      (&reg_wdata[2*`FFI_PAIR_PUMP_CAP+1 -: 2]);
   assign input_overcurrent_ack = wr_supply &&
      (&reg_wdata[2*`FFI_PAIR_IN_OVERCURRENT+1 -: 2]);
   assign regulator_undervolt_ack = wr_supply &&
      (&reg_wdata[2*`FFI_PAIR_REG_UNDERVOLT+1 -: 2]);
   assign input_overvolt_ack = wr_supply &&
      (&reg_wdata[2*`FFI_PAIR_IN_OVERVOLT+1 -: 2]);
   assign input_undervolt_ack = wr_supply &&
      (&reg_wdata[2*`FFI_PAIR_IN_UNDERVOLT+1 -: 2]);

   assign supply_clr[`FFI_PAIR_CHECKSUM] = checksum_fault_ack;
   assign supply_clr[`FFI_PAIR_SYNC_LOSS] = sync_loss_ack;
   assign supply_clr[`FFI_PAIR_PUMP] = pump_fault_ack;
   assign supply_clr[`FFI_PAIR_PUMP_CAP] = pump_capacitor_ack;
   assign supply_clr[`FFI_PAIR_IN_OVERCURRENT] = input_overcurrent_ack;
   assign supply_clr[`FFI_PAIR_REG_UNDERVOLT] = regulator_undervolt_ack;
   assign supply_clr[`FFI_PAIR_IN_OVERVOLT] = input_overvolt_ack;
   assign supply_clr[`FFI_PAIR_IN_UNDERVOLT] = input_undervolt_ack;

   // -------------------------------------------------------------------
   // Named LED-side enable states
   // -------------------------------------------------------------------
   wire logic led_fault_irq_gate;
   wire logic bad_string_cfg_irq_gate;
   wire logic bus_timeout_irq_gate;

   assign led_fault_irq_gate = field_on[F_LEDF];
   assign bad_string_cfg_irq_gate = field_on[F_STRING];
   assign bus_timeout_irq_gate = field_on[F_TIMEOUT];

   // -------------------------------------------------------------------
   // Interrupt combine
   // -------------------------------------------------------------------
   wire logic supply_any;
   wire logic conv_any;
   wire logic led_side_any;
   wire logic next_fault_irq;

   assign supply_any = |{
      checksum_fault_flag & supply_irq_gate[`FFI_PAIR_CHECKSUM],
      sync_loss_flag & supply_irq_gate[`FFI_PAIR_SYNC_LOSS],
      pump_fault_flag & supply_irq_gate[`FFI_PAIR_PUMP],
      pump_capacitor_flag & supply_irq_gate[`FFI_PAIR_PUMP_CAP],
      input_overcurrent_flag & supply_irq_gate[`FFI_PAIR_IN_OVERCURRENT],
      regulator_undervolt_flag & supply_irq_gate[`FFI_PAIR_REG_UNDERVOLT],
      input_overvolt_flag & supply_irq_gate[`FFI_PAIR_IN_OVERVOLT],
      input_undervolt_flag & supply_irq_gate[`FFI_PAIR_IN_UNDERVOLT]
   };
   assign conv_any = |(conv_flag_q & conv_irq_gate);
   assign led_side_any = (bus_timeout_flag && bus_timeout_irq_gate) ||
                         (bad_string_flag && bad_string_cfg_irq_gate) ||
                         (led_fault_flag && led_fault_irq_gate);
   assign next_fault_irq = field_on[F_GLOBAL] &&
                           (supply_any || conv_any || led_side_any);

   // Registered so the pin never glitches while the terms change
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         fault_irq <= 1'b0;
         global_irq_on <= 1'b0;
         supply_flags <= '0;
         conv_flags <= '0;
      end else begin
         fault_irq <= next_fault_irq;
         global_irq_on <= field_on[F_GLOBAL];
         supply_flags <= supply_flag_q;
         conv_flags <= conv_flag_q;
      end
   end

   // -------------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------------
   wire logic [15:0] next_rdata;

   assign next_rdata = !reg_rd ? 16'h0000 :
                       (reg_sel == FFI_SEL_LED_EN) ? led_en_rd :
                       (reg_sel == FFI_SEL_SUPPLY) ? supply_rd :
                       (reg_sel == FFI_SEL_CONV) ? conv_rd : 16'h0000;

   // Data stand only in the cycle after the read strobe
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

endmodule
`default_nettype wire

// *** tb/ffi_properties.sv ***
// Port-level assertions for the fault interrupt block
`include "ffi_map.svh"
`default_nettype none
module ffi_properties #(
   parameter int PAIRS = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic [PAIRS-1:0] supply_fault_in,
   input wire logic [PAIRS-1:0] conv_fault_in,
   input wire logic [PAIRS-1:0] supply_irq_gate,
   input wire logic [PAIRS-1:0] conv_irq_gate,
   input wire logic bus_timeout_flag,
   input wire logic bad_string_flag,
   input wire logic led_fault_flag,
   input wire logic fault_irq,
   input wire logic global_irq_on,
   input wire logic [PAIRS-1:0] supply_flags,
   input wire logic [PAIRS-1:0] conv_flags
);
   wire logic no_cause = ~|{supply_flags, conv_flags, bus_timeout_flag,
      bad_string_flag, led_fault_flag};
   wire logic en_wr = reg_wr && reg_addr == `FFI_OFS_LED_EN;
   wire logic mapped = reg_addr == `FFI_OFS_LED_EN ||
      reg_addr == `FFI_OFS_SUPPLY || reg_addr == `FFI_OFS_CONV;

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_fault_seen(int k);
      $rose(supply_fault_in[k]);
   endsequence

   a_rd_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside answer cycle");
   a_rd_enable: assert property (reg_rd && reg_addr == `FFI_OFS_LED_EN
      |=> (reg_rdata & 16'hFF55) == 16'h0000)
      else $error("enable register read shows illegal bits");
   a_rd_supply: assert property (reg_rd && reg_addr == `FFI_OFS_SUPPLY
      |=> (reg_rdata & 16'h5555) == 16'h0000)
      else $error("supply clear bits read nonzero");
   a_rd_unmapped: assert property (reg_rd && !mapped
      |=> reg_rdata == 16'h0000)
      else $error("unmapped read returned data");
   a_global_off: assert property (en_wr && reg_wdata[7:6] == 2'h1
      |-> ##2 !global_irq_on)
      else $error("global enable did not turn off");
   a_global_on: assert property (en_wr && reg_wdata[7:6] == 2'h3
      |-> ##2 global_irq_on)
      else $error("global enable did not turn on");
   a_irq_quiet: assert property (no_cause && $past(no_cause)
      |-> !fault_irq)
      else $error("interrupt without any flag");

   for (genvar k = 0; k < PAIRS; k++) begin : g_pair
      a_flag_sets: assert property (s_fault_seen(k)
         |-> ##[3:5] supply_flags[k])
         else $error("supply flag did not latch");
      a_flag_sticky: assert property ($fell(supply_flags[k])
         |-> $past(reg_wr, 2) && $past(reg_addr, 2) == `FFI_OFS_SUPPLY &&
         $past(reg_wdata[2*k+1], 2) && $past(reg_wdata[2*k], 2))
         else $error("supply flag dropped without paired clear");
      a_irq_supply: assert property ($rose(supply_fault_in[k]) &&
         supply_irq_gate[k] && global_irq_on |-> ##[3:5] fault_irq)
         else $error("enabled supply fault raised no interrupt");
   end
endmodule

bind ffi_top ffi_properties #(.PAIRS(PAIRS)) ffi_properties_inst (
   .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .supply_fault_in(supply_fault_in),
   .conv_fault_in(conv_fault_in), .supply_irq_gate(supply_irq_gate),
   .conv_irq_gate(conv_irq_gate), .bus_timeout_flag(bus_timeout_flag),
   .bad_string_flag(bad_string_flag), .led_fault_flag(led_fault_flag),
   .fault_irq(fault_irq), .global_irq_on(global_irq_on),
   .supply_flags(supply_flags), .conv_flags(conv_flags));
`default_nettype wire

// *** tb/ffi_host_model.sv ***
// Host controller model driving the register port
`default_nettype none
module ffi_host_model (
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic mclk,
   input wire logic [15:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      // Stale data is inverted so nothing leans on it
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// *** tb/tb_fault_interrupt_enable_status.sv ***
// Self-checking bench for the fault interrupt block
`default_nettype none
module tb_fault_interrupt_enable_status import ffi_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] sup_in = 8'h00;
   logic [7:0] conv_in = 8'h00;
   logic [7:0] sup_gate = 8'hFF;
   logic [2:0] led_side = 3'h0;
   logic fault_irq;
   logic global_irq_on;
   logic [7:0] sup_flags;
   logic [7:0] cv_flags;
   int failures = 0;
   int check_count = 0;

   ffi_top ffi_top_inst (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .supply_fault_in(sup_in),
      .conv_fault_in(conv_in), .supply_irq_gate(sup_gate),
      .conv_irq_gate(8'hFF), .bus_timeout_flag(led_side[2]),
      .bad_string_flag(led_side[1]), .led_fault_flag(led_side[0]),
      .fault_irq(fault_irq), .global_irq_on(global_irq_on),
      .supply_flags(sup_flags), .conv_flags(cv_flags));
   ffi_host_model ffi_host_model_inst (.mclk(mclk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   task automatic chk(input string name, input ffi_word_t exp,
      input ffi_word_t seen);
      check_count++;
      if (seen !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
         failures++;
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic rdchk(input string name, input logic [7:0] a,
      input ffi_word_t exp);
      ffi_word_t d;
      ffi_host_model_inst.rd(a, d);
      chk(name, exp, d);
   endtask
   task automatic wr(input logic [7:0] a, input ffi_word_t d);
      ffi_host_model_inst.wr(a, d);
   endtask
   task automatic irq_is(input logic v);
      chk("fault_irq", {15'h0, v}, {15'h0, fault_irq});
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_reset_regs();
      rdchk("led_en", 8'h0C, 16'h00AA);
      rdchk("supply", 8'h0E, 16'h0000);
      rdchk("conv", 8'h10, 16'h0000);
      rdchk("unmapped", 8'h20, 16'h0000);
   endtask
   task automatic t_enable_codes();
      wr(8'h0C, 16'hFF00);
      rdchk("reserved", 8'h0C, 16'h00AA);
      for (int i = 0; i < 4; i++) begin
         wr(8'h0C, 16'h1 << 2*i);
         rdchk("field_off", 8'h0C, 16'h00AA & ~(16'h2 << 2*i));
         wr(8'h0C, 16'h3 << 2*i);
         rdchk("field_on", 8'h0C, 16'h00AA);
      end
      wr(8'h0C, 16'h0055);
      rdchk("all_off", 8'h0C, 16'h0000);
      wr(8'h0C, 16'h00AA);
      rdchk("code2_ignored", 8'h0C, 16'h0000);
      wr(8'h0C, 16'h00FF);
      rdchk("all_on", 8'h0C, 16'h00AA);
   endtask
   task automatic t_supply_pairs();
      for (int k = 0; k < 8; k++) begin
         @(posedge mclk);
         sup_in <= 8'h01 << k;
         tick(6);
         irq_is(1'b1);
         chk("supply_flags", 16'h1 << k, {8'h0, sup_flags});
         rdchk("flag_set", 8'h0E, 16'h2 << 2*k);
         @(posedge mclk);
         sup_in <= 8'h00;
         wr(8'h0E, 16'h2 << 2*k);
         wr(8'h0E, 16'h1 << 2*k);
         rdchk("half_write", 8'h0E, 16'h2 << 2*k);
         irq_is(1'b1);
         wr(8'h0E, 16'h3 << 2*k);
         tick(2);
         irq_is(1'b0);
         rdchk("cleared", 8'h0E, 16'h0000);
         chk("supply_clr", 16'h0, {8'h0, sup_flags});
      end
   endtask
   task automatic t_gated_and_conv();
      @(posedge mclk);
      sup_gate <= 8'h7F;
      sup_in <= 8'h80;
      tick(6);
      irq_is(1'b0);
      rdchk("gated_flag", 8'h0E, 16'h8000);
      @(posedge mclk);
      sup_in <= 8'h00;
      conv_in <= 8'h08;
      // Let the fault leave the synchroniser, else set wins over clear
      tick(2);
      wr(8'h0E, 16'hC000);
      tick(6);
      irq_is(1'b1);
      chk("conv_flags", 16'h0008, {8'h0, cv_flags});
      rdchk("conv_flag", 8'h10, 16'h0080);
      rdchk("gated_clr", 8'h0E, 16'h0000);
      @(posedge mclk);
      conv_in <= 8'h00;
      sup_gate <= 8'hFF;
      tick(2);
      wr(8'h10, 16'h00C0);
      tick(2);
      irq_is(1'b0);
      chk("conv_clr", 16'h0, {8'h0, cv_flags});
   endtask
   task automatic t_led_side();
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk);
         led_side <= 3'h1 << i;
         tick(3);
         irq_is(1'b1);
         wr(8'h0C, 16'h0040);
         tick(2);
         irq_is(1'b0);
         chk("global", 16'h0, {15'h0, global_irq_on});
         wr(8'h0C, 16'h00C0);
         tick(2);
         irq_is(1'b1);
         chk("global_on", 16'h1, {15'h0, global_irq_on});
         wr(8'h0C, 16'h1 << 2*i);
         tick(2);
         irq_is(1'b0);
         wr(8'h0C, 16'h3 << 2*i);
         @(posedge mclk);
         led_side <= 3'h0;
         tick(3);
         irq_is(1'b0);
      end
   endtask

   // ------------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      forever #4 mclk = ~mclk;
   end
   initial begin
      // Run needs about 350 cycles; over forty times that is a hang
      #120000;
      failures++;
      give_verdict();
   end
   initial begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset_regs();
      t_enable_codes();
      t_supply_pairs();
      t_gated_and_conv();
      t_led_side();
      give_verdict();
   end
endmodule
`default_nettype wire
